/* File: rtl/spi_rx_queue_ctrl.sv */
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ns
// What this block does
// - Report stored word count, zero to four
// - Full queue plus new word sets overflow
// - Overflow flag is read-only to software
// - Writing one to overflow clear clears it
// - Queue reset bit zero holds queue empty
// - Count at or above threshold sets flag
// - Level flag read-only, shows condition occurred
// - Writing one to level clear clears flag
// - Enable bit gates the level interrupt
// - Threshold resets to all ones
// - Queue fills and flags set only when enhanced
module spi_rx_queue_ctrl (
	input  wire logic                        clk,           // Peripheral clock, 50 MHz
	input  wire logic                        rst_n,         // Asynchronous reset, active low
	input  wire logic [rxq_pkg::ADDR_W-1:0]  awaddr,        // Write address
	input  wire logic                        awvalid,       // Write address valid
	output      logic                        awready,       // Write address ready
	input  wire logic [rxq_pkg::DATA_W-1:0]  wdata,         // Write data
	input  wire logic [3:0]                  wstrb,         // Write byte strobes
	input  wire logic                        wvalid,        // Write data valid
	output      logic                        wready,        // Write data ready
	output      logic [1:0]                  bresp,         // Write response
	output      logic                        bvalid,        // Write response valid
	input  wire logic                        bready,        // Write response ready
	input  wire logic [rxq_pkg::ADDR_W-1:0]  araddr,        // Read address
	input  wire logic                        arvalid,       // Read address valid
	output      logic                        arready,       // Read address ready
	output      logic [rxq_pkg::DATA_W-1:0]  rdata,         // Read data
	output      logic [1:0]                  rresp,         // Read response
	output      logic                        rvalid,        // Read data valid
	input  wire logic                        rready,        // Read data ready
	input  wire logic                        rx_word_valid, // Word done in shift register
	input  wire logic [rxq_pkg::WORD_W-1:0]  rx_word,       // Received word
	output      logic                        irq,           // Masked event interrupt
	output      logic                        rx_level_irq   // Level request to controller
);
	localparam int CW = rxq_pkg::CNT_W;
	localparam int WW = rxq_pkg::WORD_W;

	rxq_store_if #(.WIDTH(WW), .CNT_W(CW)) sif ();

	rxq_store #(.WIDTH(WW), .DEPTH(rxq_pkg::DEPTH), .CNT_W(CW)) u_store (
		.clk   (clk),
		.rst_n (rst_n),
		.sif   (sif)
	);

	// -----------------------------------------------------------------
	// Bus slave state
	// -----------------------------------------------------------------
	logic                       awready_q;
	logic                       wready_q;
	logic                       bvalid_q;
	logic [1:0]                 bresp_q;
	logic                       arready_q;
	logic                       rvalid_q;
	logic [1:0]                 rresp_q;
	logic [rxq_pkg::DATA_W-1:0] rdata_q;
	logic [rxq_pkg::ADDR_W-1:0] aw_addr_q;
	logic                       aw_full_q;
	logic [rxq_pkg::DATA_W-1:0] w_data_q;
	logic [3:0]                 w_strb_q;
	logic                       w_full_q;

	// -----------------------------------------------------------------
	// Block registers
	// -----------------------------------------------------------------
	logic                       enh_q;
	logic                       qrst_q;
	logic                       ien_q;
	logic [CW-1:0]              level_q;
	logic                       ovf_q;
	logic                       ovf_d;
	logic                       flag_q;
	logic                       flag_d;
	logic [rxq_pkg::DLY_W-1:0]  dly_q;
	logic [rxq_pkg::EV_W-1:0]   stat_q;
	logic [rxq_pkg::EV_W-1:0]   stat_d;
	logic [rxq_pkg::EV_W-1:0]   mask_q;
	logic                       irq_q;
	logic                       lvl_irq_q;

	// -----------------------------------------------------------------
	// Handshakes and decode
	// -----------------------------------------------------------------
	logic                       aw_hs;
	logic                       w_hs;
	logic                       ar_hs;
	logic                       do_write;
	logic                       wr_lo;
	logic                       wr_hi;
	logic                       wsel_enh;
	logic                       wsel_rx;
	logic                       wsel_fc;
	logic                       wsel_stat;
	logic                       wsel_mask;
	logic                       wr_mapped;
	logic                       rd_mapped;
	logic                       rd_pop;
	logic [rxq_pkg::DATA_W-1:0] rd_word;
	logic [WW-1:0]              rx_view;

	assign aw_hs    = awvalid & awready_q;
	assign w_hs     = wvalid & wready_q;
	assign ar_hs    = arvalid & arready_q;
	// Write fires once address and data are both held and no answer waits
	assign do_write = aw_full_q & w_full_q & ~bvalid_q;
	assign wsel_enh  = (aw_addr_q == rxq_pkg::OFF_ENH_CTRL);
	assign wsel_rx   = (aw_addr_q == rxq_pkg::OFF_RX_CTRL);
	assign wsel_fc   = (aw_addr_q == rxq_pkg::OFF_FIFO_CTRL);
	assign wsel_stat = (aw_addr_q == rxq_pkg::OFF_IRQ_STAT);
	assign wsel_mask = (aw_addr_q == rxq_pkg::OFF_IRQ_MASK);
	// The data port is read-only, so a write to it answers as unmapped
	assign wr_mapped = wsel_enh | wsel_rx | wsel_fc | wsel_stat | wsel_mask;
	assign wr_lo     = do_write & w_strb_q[0];
	assign wr_hi     = do_write & w_strb_q[1];
	assign rd_mapped = (araddr == rxq_pkg::OFF_ENH_CTRL) | (araddr == rxq_pkg::OFF_RX_CTRL)
	                 | (araddr == rxq_pkg::OFF_FIFO_CTRL) | (araddr == rxq_pkg::OFF_IRQ_STAT)
	                 | (araddr == rxq_pkg::OFF_IRQ_MASK) | (araddr == rxq_pkg::OFF_RX_DATA);
	assign rd_pop    = ar_hs & (araddr == rxq_pkg::OFF_RX_DATA);

	// -----------------------------------------------------------------
	// Queue steering and event logic
	// -----------------------------------------------------------------
	logic queue_active;
	logic ovf_clr;
	logic flag_clr;
	logic level_met;
	logic ovf_event;
	logic lvl_event;
	logic [rxq_pkg::EV_W-1:0] stat_clr;
	logic [rxq_pkg::EV_W-1:0] events;

	// Queue runs only when enhanced and out of reset
	assign queue_active  = enh_q & qrst_q;
	assign sif.clr       = ~queue_active;
	assign sif.push      = rx_word_valid & queue_active;
	assign sif.push_data = rx_word;
	assign sif.pop       = rd_pop & queue_active;
	assign ovf_clr   = wr_hi & wsel_rx & w_data_q[rxq_pkg::OVF_CLR_BIT];
	assign flag_clr  = wr_lo & wsel_rx & w_data_q[rxq_pkg::LVL_CLR_BIT];
	assign level_met = queue_active & (sif.count >= level_q);
	assign ovf_event = sif.drop;
	assign lvl_event = level_met & ~flag_q;
	// A fresh event beats a clear written in the same cycle
	assign ovf_d     = ovf_event | (ovf_q & ~ovf_clr);
	assign flag_d    = level_met | (flag_q & ~flag_clr);
	assign events    = {lvl_event, ovf_event};
	assign stat_clr  = (wr_lo & wsel_stat) ? w_data_q[rxq_pkg::EV_W-1:0] : '0;
	assign stat_d    = events | (stat_q & ~stat_clr);

	// Clear bits always read back as zero
	assign rx_view = {ovf_q, 1'b0, qrst_q, sif.count, flag_q, 1'b0, ien_q, level_q};

	// Read selection; unmapped words read as zero
	assign rd_word =
		(araddr == rxq_pkg::OFF_ENH_CTRL)  ? {31'h00000000, enh_q} :
		(araddr == rxq_pkg::OFF_RX_CTRL)   ? {16'h0000, rx_view} :
		(araddr == rxq_pkg::OFF_FIFO_CTRL) ? {24'h000000, dly_q} :
		(araddr == rxq_pkg::OFF_IRQ_STAT)  ? {30'h00000000, stat_q} :
		(araddr == rxq_pkg::OFF_IRQ_MASK)  ? {30'h00000000, mask_q} :
		(araddr == rxq_pkg::OFF_RX_DATA && !sif.empty) ? {16'h0000, sif.pop_data} :
		32'h00000000;

	// -----------------------------------------------------------------
	// Write channel capture
	// -----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			awready_q <= 1'b1;
			aw_full_q <= 1'b0;
			aw_addr_q <= '0;
		end else if (aw_hs) begin
			awready_q <= 1'b0;
			aw_full_q <= 1'b1;
			aw_addr_q <= awaddr;
		end else if (do_write) begin
			awready_q <= 1'b1;
			aw_full_q <= 1'b0;
		end
	end

	// Data is held until its address also arrives, in either order
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wready_q <= 1'b1;
			w_full_q <= 1'b0;
			w_data_q <= '0;
			w_strb_q <= '0;
		end else if (w_hs) begin
			wready_q <= 1'b0;
			w_full_q <= 1'b1;
			w_data_q <= wdata;
			w_strb_q <= wstrb;
		end else if (do_write) begin
			wready_q <= 1'b1;
			w_full_q <= 1'b0;
		end
	end

	// Write response
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bvalid_q <= 1'b0;
			bresp_q  <= rxq_pkg::RESP_OKAY;
		end else if (do_write) begin
			bvalid_q <= 1'b1;
			bresp_q  <= wr_mapped ? rxq_pkg::RESP_OKAY : rxq_pkg::RESP_SLV;
		end else if (bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// Read channel; one read in flight, answered the cycle after the address
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			arready_q <= 1'b1;
			rvalid_q  <= 1'b0;
			rresp_q   <= rxq_pkg::RESP_OKAY;
			rdata_q   <= '0;
		end else if (ar_hs) begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b1;
			rresp_q   <= rd_mapped ? rxq_pkg::RESP_OKAY : rxq_pkg::RESP_SLV;
			rdata_q   <= rd_word;
		end else if (rvalid_q && rready) begin
			arready_q <= 1'b1;
			rvalid_q  <= 1'b0;
		end
	end

	// -----------------------------------------------------------------
	// Software-written controls
	// -----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			enh_q   <= rxq_pkg::ENH_RST;
			qrst_q  <= rxq_pkg::QRST_RST;
			ien_q   <= rxq_pkg::IEN_RST;
			level_q <= rxq_pkg::LEVEL_RST;
			dly_q   <= rxq_pkg::DLY_RST;
			mask_q  <= rxq_pkg::MASK_RST;
		end else begin
			if (wr_lo && wsel_enh) enh_q <= w_data_q[rxq_pkg::ENH_BIT];
			if (wr_hi && wsel_rx) qrst_q <= w_data_q[rxq_pkg::QRST_BIT];
			if (wr_lo && wsel_rx) ien_q <= w_data_q[rxq_pkg::LVL_IEN_BIT];
			if (wr_lo && wsel_rx) level_q <= w_data_q[rxq_pkg::LVL_LSB +: CW];
			if (wr_lo && wsel_fc) dly_q <= w_data_q[rxq_pkg::DLY_W-1:0];
			if (wr_lo && wsel_mask) mask_q <= w_data_q[rxq_pkg::EV_W-1:0];
		end
	end

	// Hardware flags and interrupt outputs, all registered
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ovf_q     <= 1'b0;
			flag_q    <= 1'b0;
			stat_q    <= '0;
			irq_q     <= 1'b0;
			lvl_irq_q <= 1'b0;
		end else begin
			ovf_q     <= ovf_d;
			flag_q    <= flag_d;
			stat_q    <= stat_d;
			irq_q     <= |(stat_d & mask_q);
			lvl_irq_q <= flag_d & ien_q;
		end
	end

	assign awready      = awready_q;
	assign wready       = wready_q;
	assign bvalid       = bvalid_q;
	assign bresp        = bresp_q;
	assign arready      = arready_q;
	assign rvalid       = rvalid_q;
	assign rresp        = rresp_q;
	assign rdata        = rdata_q;
	assign irq          = irq_q;
	assign rx_level_irq = lvl_irq_q;

	// -----------------------------------------------------------------
	// Checks
	// -----------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	logic first_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) first_q <= 1'b1;
		else first_q <= 1'b0;
	end

	property p_count_range;
		sif.count <= 5'h04;
	endproperty
	a_count_range: assert property (p_count_range) else $error("count above four");

	property p_ovf_set;
		sif.push && sif.full && !sif.pop |=> ovf_q && sif.count == 5'h04;
	endproperty
	a_ovf_set: assert property (p_ovf_set) else $error("overflow not flagged");

	property p_ovf_hold;
		ovf_q && !(wr_hi && wsel_rx && w_data_q[rxq_pkg::OVF_CLR_BIT]) |=> ovf_q;
	endproperty
	a_ovf_hold: assert property (p_ovf_hold) else $error("overflow lost without clear");

	property p_ovf_clr;
		ovf_clr && !sif.drop |=> !ovf_q;
	endproperty
	a_ovf_clr: assert property (p_ovf_clr) else $error("overflow clear ignored");

	// Flags keep their value while the queue is held; only the level empties
	property p_qreset;
		!qrst_q |=> sif.count == 5'h00;
	endproperty
	a_qreset: assert property (p_qreset) else $error("queue not held");

	property p_level;
		queue_active && sif.count >= level_q |=> flag_q;
	endproperty
	a_level: assert property (p_level) else $error("level flag not set");

	property p_flag_hold;
		flag_q && !flag_clr |=> flag_q [*1];
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("level flag dropped");

	property p_flag_clr;
		flag_clr && !level_met |=> !flag_q;
	endproperty
	a_flag_clr: assert property (p_flag_clr) else $error("level clear ignored");

	property p_gate;
		!ien_q && $stable(ien_q) |=> !rx_level_irq;
	endproperty
	a_gate: assert property (p_gate) else $error("disabled level request seen");

	property p_level_rst;
		first_q |-> level_q == 5'h1F;
	endproperty
	a_level_rst: assert property (p_level_rst) else $error("threshold reset wrong");

	// A sticky flag may outlive the enable, so only new activity is barred
	property p_enh_off;
		!enh_q |-> (!sif.push && !level_met) ##1 sif.count == 5'h00;
	endproperty
	a_enh_off: assert property (p_enh_off) else $error("queue active while plain");

	property p_req;
		rx_level_irq == $past(flag_d & ien_q, 1);
	endproperty
	a_req: assert property (p_req) else $error("level request mismatch");

	c_overflow: cover property (sif.drop ##1 ovf_q);
	c_level:    cover property (lvl_event ##1 rx_level_irq);
	c_pop:      cover property (sif.pop && !sif.empty);
endmodule

/* File: common/rxq_pkg.sv */
package rxq_pkg;

	// -----------------------------------------------------------------
	// Widths and sizes
	// -----------------------------------------------------------------
	localparam int DATA_W  = 32;
	localparam int ADDR_W  = 16;
	localparam int WORD_W  = 16;
	localparam int DEPTH   = 4;
	localparam int CNT_W   = 5;
	localparam int DLY_W   = 8;
	localparam int EV_W    = 2;

	// -----------------------------------------------------------------
	// Register byte addresses
	// -----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFF_ENH_CTRL  = 16'h7044;
	localparam logic [ADDR_W-1:0] OFF_RX_CTRL   = 16'h7048;
	localparam logic [ADDR_W-1:0] OFF_FIFO_CTRL = 16'h704C;
	localparam logic [ADDR_W-1:0] OFF_IRQ_STAT  = 16'h7050;
	localparam logic [ADDR_W-1:0] OFF_IRQ_MASK  = 16'h7054;
	localparam logic [ADDR_W-1:0] OFF_RX_DATA   = 16'h7058;

	// -----------------------------------------------------------------
	// Field positions of the receive queue control and status register, the enhanced control bit and the event bits
	// -----------------------------------------------------------------
	localparam int OVF_BIT      = 15;
	localparam int OVF_CLR_BIT  = 14;
	localparam int QRST_BIT     = 13;
	localparam int CNT_LSB      = 8;
	localparam int LVL_FLAG_BIT = 7;
	localparam int LVL_CLR_BIT  = 6;
	localparam int LVL_IEN_BIT  = 5;
	localparam int LVL_LSB      = 0;
	localparam int ENH_BIT      = 0;
	localparam int EV_OVF       = 0;
	localparam int EV_LVL       = 1;

	// -----------------------------------------------------------------
	// Reset values and bus answers
	// -----------------------------------------------------------------
	localparam logic [CNT_W-1:0] LEVEL_RST = 5'h1F;
	localparam logic             QRST_RST  = 1'h1;
	localparam logic             ENH_RST   = 1'h0;
	localparam logic             IEN_RST   = 1'h0;
	localparam logic [DLY_W-1:0] DLY_RST   = 8'h00;
	localparam logic [EV_W-1:0]  MASK_RST  = 2'h0;
	localparam logic [1:0]       RESP_OKAY = 2'h0;
	localparam logic [1:0]       RESP_SLV  = 2'h2;

endpackage

/* File: common/rxq_store_if.sv */
`timescale 1ns/1ns
// Carries push, pop and level between the queue control and its storage
interface rxq_store_if #(
	parameter int WIDTH = 16,
	parameter int CNT_W = 5
);
	logic             push;
	logic [WIDTH-1:0] push_data;
	logic             pop;
	logic             clr;
	logic [WIDTH-1:0] pop_data;
	logic [CNT_W-1:0] count;
	logic             full;
	logic             empty;
	logic             drop;

	modport ctrl  (output push, push_data, pop, clr, input pop_data, count, full, empty, drop);
	modport store (input push, push_data, pop, clr, output pop_data, count, full, empty, drop);
endinterface

/* File: rtl/rxq_store.sv */
`timescale 1ns/1ns
module rxq_store #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 4,
	parameter int CNT_W = 5
) (
	input wire logic     clk,     // Peripheral clock
	input wire logic     rst_n,   // Asynchronous reset, active low
	rxq_store_if.store   sif      // Push, pop and level
);
	localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PTR_W-1:0] wr_ptr_q;
	logic [PTR_W-1:0] rd_ptr_q;
	logic [CNT_W-1:0] cnt_q;
	logic [PTR_W-1:0] wr_nxt;
	logic [PTR_W-1:0] rd_nxt;
	logic             do_pop;
	logic             grow;
	logic             shrink;

	// -----------------------------------------------------------------
	// Level and pointer stepping
	// -----------------------------------------------------------------
	assign sif.full     = (cnt_q == CNT_W'(DEPTH));
	assign sif.empty    = (cnt_q == '0);
	assign sif.count    = cnt_q;
	assign sif.pop_data = mem_q[rd_ptr_q];
	assign do_pop       = sif.pop & ~sif.empty;
	// A word landing on a full queue overwrites the oldest one
	assign sif.drop     = sif.push & sif.full & ~do_pop;
	assign grow         = sif.push & ~do_pop & ~sif.full;
	assign shrink       = do_pop & ~sif.push;
	assign wr_nxt       = (wr_ptr_q == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
	assign rd_nxt       = (rd_ptr_q == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;

	// Storage carries no reset; stale words are never visible past empty
	always_ff @(posedge clk) begin
		if (sif.push && !sif.clr) begin
			mem_q[wr_ptr_q] <= sif.push_data;
		end
	end

	// Pointers and count; clear holds everything at zero
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			cnt_q    <= '0;
		end else if (sif.clr) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			cnt_q    <= '0;
		end else begin
			if (sif.push) wr_ptr_q <= wr_nxt;
			if (do_pop || sif.drop) rd_ptr_q <= rd_nxt;
			if (grow) cnt_q <= cnt_q + 1'b1;
			else if (shrink) cnt_q <= cnt_q - 1'b1;
		end
	end
endmodule

/* File: bench/rx_word_source.sv */
`timescale 1ns/1ns
// ---------------------------------------------------------------
// Shift register stand-in: one word per one-cycle pulse
// ---------------------------------------------------------------
module rx_word_source (
	input  wire logic        clk,           // Peripheral clock
	output      logic        rx_word_valid, // Word done pulse
	output      logic [15:0] rx_word        // Received word
);
	// Idle word is the inverse of the last one so stale data never looks valid
	initial begin
		rx_word_valid = 1'b0;
		rx_word       = 16'h0000;
	end

	// Pulse lasts exactly one clock, the way a finished shift does
	task automatic send(input logic [15:0] w);
		@(posedge clk);
		rx_word_valid <= 1'b1;
		rx_word       <= w;
		@(posedge clk);
		rx_word_valid <= 1'b0;
		rx_word       <= ~w;
	endtask
endmodule

/* File: bench/test_spi_receive_fifo_control.sv */
`timescale 1ns/1ns
module test_spi_receive_fifo_control;
	logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid, irq, rx_level_irq;
	logic        rx_word_valid;
	logic [15:0] awaddr, araddr, rx_word;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	int          n_errors, checks_done;

	// ---------------------------------------------------------------
	// Clock, design and far side
	// ---------------------------------------------------------------
	always #10 clk = ~clk;

	spi_rx_queue_ctrl spi_rx_queue_ctrl_inst (.clk(clk), .rst_n(rst_n), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .rx_word_valid(rx_word_valid), .rx_word(rx_word), .irq(irq),
		.rx_level_irq(rx_level_irq));

	rx_word_source rx_word_source_inst (.clk(clk), .rx_word_valid(rx_word_valid),
		.rx_word(rx_word));

	// ---------------------------------------------------------------
	// Compare tasks and verdict
	// ---------------------------------------------------------------
	task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t resp got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t bit got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic results;
		$display("errors=%0d checks=%0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ---------------------------------------------------------------
	// AXI4-Lite master: hold each channel until its own ready edge
	// ---------------------------------------------------------------
	task automatic axi_write(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [1:0] r);
		bit ad, wd;
		@(posedge clk);
		awaddr  <= a;
		wdata   <= d;
		wstrb   <= s;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		ad = 0;
		wd = 0;
		forever begin
			@(posedge clk);
			if (bvalid === 1'b1 && ad && wd) break;
			if (!ad && awready === 1'b1) begin
				ad = 1;
				awvalid <= 1'b0;
			end
			if (!wd && wready === 1'b1) begin
				wd = 1;
				wvalid <= 1'b0;
			end
		end
		r = bresp;
		bready <= 1'b0;
	endtask

	task automatic axi_read(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
		bit ad;
		@(posedge clk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		ad = 0;
		forever begin
			@(posedge clk);
			if (rvalid === 1'b1 && ad) break;
			if (!ad && arready === 1'b1) begin
				ad = 1;
				arvalid <= 1'b0;
			end
		end
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	// Register access with an OKAY answer expected
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		logic [1:0] r;
		axi_write(a, d, 4'hF, r);
		chk_resp(r, rxq_pkg::RESP_OKAY);
	endtask

	task automatic rd(input logic [15:0] a, input logic [31:0] exp);
		logic [31:0] d;
		logic [1:0]  r;
		axi_read(a, d, r);
		chk_resp(r, rxq_pkg::RESP_OKAY);
		chk_data(d, exp);
	endtask

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic t_reset_and_disabled;
		rd(rxq_pkg::OFF_RX_CTRL, 32'h0000201F);
		rd(rxq_pkg::OFF_ENH_CTRL, 32'h00000000);
		rd(rxq_pkg::OFF_IRQ_MASK, 32'h00000000);
		rx_word_source_inst.send(16'hC000);
		rd(rxq_pkg::OFF_RX_CTRL, 32'h0000201F);
	endtask

	// Threshold three reached by the third word, request follows the flag
	task automatic t_level;
		wr(rxq_pkg::OFF_ENH_CTRL, 32'h00000001);
		wr(rxq_pkg::OFF_RX_CTRL, 32'h00002023);
		rx_word_source_inst.send(16'hC001);
		rx_word_source_inst.send(16'hC002);
		rd(rxq_pkg::OFF_RX_CTRL, 32'h00002223);
		chk_bit(rx_level_irq, 1'b0);
		rx_word_source_inst.send(16'hC003);
		rd(rxq_pkg::OFF_RX_CTRL, 32'h000023A3);
		chk_bit(rx_level_irq, 1'b1);
	endtask

	// Fifth word on a full queue; flag ignores software writes of one
	task automatic t_overflow;
		rx_word_source_inst.send(16'hC004);
		rx_word_source_inst.send(16'hC005);
		rd(rxq_pkg::OFF_RX_CTRL, 32'h0000A4A3);
		chk_bit(irq, 1'b0);
		wr(rxq_pkg::OFF_IRQ_MASK, 32'h00000001);
		rd(rxq_pkg::OFF_IRQ_STAT, 32'h00000003);
		chk_bit(irq, 1'b1);
		wr(rxq_pkg::OFF_RX_CTRL, 32'h0000A023);
		rd(rxq_pkg::OFF_RX_CTRL, 32'h0000A4A3);
		wr(rxq_pkg::OFF_RX_CTRL, 32'h00006023);
		rd(rxq_pkg::OFF_RX_CTRL, 32'h000024A3);
	endtask

	// Oldest word was lost; flag stays sticky until its clear bit
	task automatic t_drain;
		int i;
		for (i = 2; i <= 5; i++) begin
			rd(rxq_pkg::OFF_RX_DATA, 32'h0000C000 + i);
		end
		rd(rxq_pkg::OFF_RX_DATA, 32'h00000000);
		rd(rxq_pkg::OFF_RX_CTRL, 32'h000020A3);
		wr(rxq_pkg::OFF_RX_CTRL, 32'h00002063);
		rd(rxq_pkg::OFF_RX_CTRL, 32'h00002023);
		chk_bit(rx_level_irq, 1'b0);
		wr(rxq_pkg::OFF_IRQ_STAT, 32'h00000003);
		rd(rxq_pkg::OFF_IRQ_STAT, 32'h00000000);
		chk_bit(irq, 1'b0);
	endtask

	// Queue held empty while its reset bit is zero; enable gates request
	task automatic t_qreset_enable;
		rx_word_source_inst.send(16'hC006);
		rx_word_source_inst.send(16'hC007);
		wr(rxq_pkg::OFF_RX_CTRL, 32'h00000023);
		rd(rxq_pkg::OFF_RX_CTRL, 32'h00000023);
		rx_word_source_inst.send(16'hC008);
		rd(rxq_pkg::OFF_RX_CTRL, 32'h00000023);
		wr(rxq_pkg::OFF_RX_CTRL, 32'h00002001);
		rx_word_source_inst.send(16'hC009);
		rd(rxq_pkg::OFF_RX_CTRL, 32'h00002181);
		chk_bit(rx_level_irq, 1'b0);
		wr(rxq_pkg::OFF_RX_CTRL, 32'h00002021);
		rd(rxq_pkg::OFF_RX_CTRL, 32'h000021A1);
		chk_bit(rx_level_irq, 1'b1);
	endtask

	// Each strobe reaches only its own byte; the delay byte is kept as written
	task automatic t_strobes;
		logic [1:0] r;
		axi_write(rxq_pkg::OFF_RX_CTRL, 32'h0000C000, 4'h2, r);
		chk_resp(r, rxq_pkg::RESP_OKAY);
		rd(rxq_pkg::OFF_RX_CTRL, 32'h000000A1);
		axi_write(rxq_pkg::OFF_RX_CTRL, 32'h0000FFFF, 4'h1, r);
		chk_resp(r, rxq_pkg::RESP_OKAY);
		rd(rxq_pkg::OFF_RX_CTRL, 32'h0000003F);
		chk_bit(rx_level_irq, 1'b0);
		wr(rxq_pkg::OFF_FIFO_CTRL, 32'h000012A5);
		rd(rxq_pkg::OFF_FIFO_CTRL, 32'h000000A5);
	endtask

	task automatic t_unmapped;
		logic [31:0] d;
		logic [1:0]  r;
		axi_read(16'h7060, d, r);
		chk_resp(r, rxq_pkg::RESP_SLV);
		chk_data(d, 32'h00000000);
		axi_write(rxq_pkg::OFF_RX_DATA, 32'h00001234, 4'hF, r);
		chk_resp(r, rxq_pkg::RESP_SLV);
	endtask

	// ---------------------------------------------------------------
	// Main sequence and watchdog
	// ---------------------------------------------------------------
	initial begin
		clk = 0; rst_n = 0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
		awaddr = 16'h0000; araddr = 16'h0000; wdata = 32'h00000000; wstrb = 4'h0;
		n_errors = 0; checks_done = 0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		t_reset_and_disabled();
		t_level();
		t_overflow();
		t_drain();
		t_qreset_enable();
		t_strobes();
		t_unmapped();
		results();
	end

	// A stuck handshake would otherwise hang the run
	initial begin
		#200000;
		n_errors++;
		results();
	end
endmodule
